/* rtl/dac_pkg.sv */
// Purpose: constants and carriers for the decimal adder and compare unit
// Assumes: characters are six-bit BCD (zone B, zone A, 8, 4, 2, 1)
// Notes: collating group table is a constant function
//
// Contract
// - take one A and one B character per cycle, return result for assembly
// - sign negative only when B zone set and A zone clear
// - true or complement add chosen from operation and both signs
// - true translation: 1 to B1, 2 to Q2, 4 to Q4, 2+4 to Q6, 8 to Q8
// - eight with four acts as four alone; non-sign zones ignored
// - add binary parts with carry in, then quinary parts, back to BCD
// - carry out of the adder sets the carry latch for the next digit
// - true/complement control forces carry or no-carry at units position
// - complement add uses nines complement of A and forced units carry
// - compare feeds both characters to compare logic and adder together
// - compare sets exactly one of high, low, equal latches, held
// - each character classified alphameric, special or non-numeric group
// - alphameric beats special or non-numeric regardless of zones, digits
// - undecided by groups, zones decide the comparison
// - undecided by zones, digits compared by B minus A in the adder
// - quinary carry with sum not Q8 reports B greater
// - no quinary carry with sum not Q8 reports B smaller
// - quinary sum Q8 decides from combined binary part
// - specials eight with three to seven act as digits three to seven
package dac_pkg;

    // ----------------------------------------------------------------
    // character layout
    // ----------------------------------------------------------------
    localparam int CHAR_W = 6;
    localparam int BIT_ZB = 5;
    localparam int BIT_ZA = 4;
    localparam int BIT_8 = 3;
    localparam int BIT_4 = 2;
    localparam int BIT_2 = 1;
    localparam int BIT_1 = 0;

    // ----------------------------------------------------------------
    // operation codes and groups
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DAC_OP_ADD = 2'b00,
        DAC_OP_SUB = 2'b01,
        DAC_OP_CMP = 2'b10,
        DAC_OP_NOP = 2'b11
    } dac_op_type;

    typedef enum logic [1:0] {
        NON_NUMERIC_GROUP = 2'b00,
        SPECIAL_CHAR_GROUP = 2'b01,
        ALPHAMERIC_GROUP = 2'b10
    } dac_group_type;

    typedef enum logic [1:0] {
        DAC_REL_EQ = 2'b00,
        DAC_REL_LO = 2'b01,
        DAC_REL_HI = 2'b10,
        DAC_REL_NONE = 2'b11
    } dac_rel_type;

    localparam logic [2:0] QUI_EIGHT = 3'h4;

    // qui-binary digit: quinary index 0..4 (Q0..Q8), binary bit
    typedef struct packed {
        logic [2:0] qui;
        logic bin;
    } dac_qb_type;

    // request from the channels
    typedef struct packed {
        logic valid;
        dac_op_type op;
        logic unitsPos;
        logic [CHAR_W-1:0] aChar;
        logic [CHAR_W-1:0] bChar;
        logic aSignNeg;
        logic bSignNeg;
    } dac_req_type;

    // answer to the assembly unit
    typedef struct packed {
        logic valid;
        logic [3:0] digit;
        logic carryOut;
        logic complement;
    } dac_res_type;

endpackage : dac_pkg

/* rtl/dac_unit.sv */
// Purpose: decimal adder and compare datapath, one character pair per cycle
// Assumes: caller logic supplies units-position characters; operand signs decoded here from their zones
// Notes: result and latches registered one cycle after the request
`timescale 1ns/10ps
`default_nettype none

module dac_unit
    import dac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // channel request
    input wire logic reqValid,
    input wire logic [1:0] reqOp,
    input wire logic reqUnitsPos,
    input wire logic [CHAR_W-1:0] aChar,
    input wire logic [CHAR_W-1:0] bChar,
    input wire logic [CHAR_W-1:0] aUnitsChar,
    input wire logic [CHAR_W-1:0] bUnitsChar,
    // result to assembly
    output logic resValid,
    output logic [3:0] resDigit,
    output logic carryLatch,
    output logic complementAdd,
    // compare latches
    output logic cmpHigh,
    output logic cmpLow,
    output logic cmpEqual
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    function automatic logic sign_neg(input logic [CHAR_W-1:0] c);
        sign_neg = c[BIT_ZB] & ~c[BIT_ZA];
    endfunction : sign_neg

    // bcd value seen by the adder
    function automatic logic [3:0] digit_of(input logic [CHAR_W-1:0] c);
        logic [3:0] d;
        d = c[3:0];
        if (c[BIT_8] && c[BIT_4]) begin
            d = {1'b0, c[2:0]};
        end else if (c[BIT_8] && (c[2:0] >= 3'h3)) begin
            d = {1'b0, c[2:0]};
        end else if (d > 4'h9) begin
            d = {1'b0, c[2:0]};
        end
        digit_of = d;
    endfunction : digit_of

    // bcd to qui-binary, optional nines complement
    function automatic dac_qb_type to_qb(input logic [3:0] d,
                                         input logic comp);
        dac_qb_type q;
        logic [3:0] v;
        v = comp ? 4'(4'h9 - d) : d;
        q.bin = v[0];
        q.qui = 3'(v[3:1]);
        to_qb = q;
    endfunction : to_qb

    // character group and collating rank, constant table
    function automatic dac_group_type group_of(input logic [CHAR_W-1:0] c);
        logic [3:0] d;
        d = c[3:0];
        if (d >= 4'h1 && d <= 4'h9) begin
            group_of = ALPHAMERIC_GROUP;
        end else if (d == 4'ha && c[5:4] != 2'h0) begin
            group_of = ALPHAMERIC_GROUP;
        end else if (d >= 4'hb) begin
            group_of = SPECIAL_CHAR_GROUP;
        end else begin
            group_of = NON_NUMERIC_GROUP;
        end
    endfunction : group_of

    function automatic logic [1:0] zone_rank(input logic [CHAR_W-1:0] c);
        unique case (c[5:4])
            2'b11: zone_rank = 2'h0;
            2'b10: zone_rank = 2'h1;
            2'b01: zone_rank = 2'h2;
            2'b00: zone_rank = 2'h3;
        endcase
    endfunction : zone_rank

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rstSync;
        logic resValid;
        logic [3:0] resDigit;
        logic carry;
        logic comp;
        logic high;
        logic low;
        logic equal;
    } dac_state_type;

    dac_state_type st_r;
    dac_state_type st_nxt;
    logic rstDone;
    logic [1:0] rstPipe_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstDone = rstPipe_r[1];

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    logic isCmp;
    logic compSel;
    logic carryIn;
    dac_qb_type qa;
    dac_qb_type qb;
    logic [1:0] binSum;
    logic [3:0] quiSum;
    logic quiCarry;
    logic [2:0] quiRes;
    logic [4:0] total;
    dac_rel_type rel;
    dac_group_type ga;
    dac_group_type gb;

    always_comb begin
        isCmp = (dac_op_type'(reqOp) == DAC_OP_CMP);
        // subtract or unlike signs flips to complement add
        compSel = isCmp | ((dac_op_type'(reqOp) == DAC_OP_SUB) ^
                  (sign_neg(aUnitsChar) ^ sign_neg(bUnitsChar)));
        // units position forces carry in complement, none in true add
        carryIn = reqUnitsPos ? compSel : st_r.carry;
        qa = to_qb(digit_of(aChar), compSel);
        qb = to_qb(digit_of(bChar), 1'b0);
        binSum = 2'({1'b0, qa.bin}) + 2'({1'b0, qb.bin}) +
                 2'({1'b0, carryIn});
        quiSum = 4'({1'b0, qa.qui}) + 4'({1'b0, qb.qui}) +
                 4'({3'h0, binSum[1]});
        quiCarry = (quiSum >= 4'h5);
        quiRes = quiCarry ? 3'(quiSum - 4'h5) : quiSum[2:0];
        total = 5'({quiRes, binSum[0]});
        // group, then zone, then digit decision
        ga = group_of(aChar);
        gb = group_of(bChar);
        if (ga != gb &&
            (ga == ALPHAMERIC_GROUP || gb == ALPHAMERIC_GROUP)) begin
            // alphameric side wins outright
            rel = (gb == ALPHAMERIC_GROUP) ?
                  DAC_REL_HI : DAC_REL_LO;
        end else if (ga != gb) begin
            rel = (gb > ga) ? DAC_REL_HI : DAC_REL_LO;
        end else if (zone_rank(aChar) != zone_rank(bChar)) begin
            rel = (zone_rank(bChar) > zone_rank(aChar)) ?
                  DAC_REL_HI : DAC_REL_LO;
        end else if ((4'({1'b0, qa.qui}) + 4'({1'b0, qb.qui})) ==
                     4'({1'b0, QUI_EIGHT})) begin
            // quinary parts met at eight, before any binary carry:
            // the combined binary part decides
            rel = (binSum == 2'h1) ? DAC_REL_LO :
                  (binSum == 2'h3) ? DAC_REL_HI :
                  DAC_REL_EQ;
        end else if ((4'({1'b0, qa.qui}) + 4'({1'b0, qb.qui})) >= 4'h5) begin
            rel = DAC_REL_HI;
        end else begin
            rel = DAC_REL_LO;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rstSync = {st_r.rstSync[0], rstDone};
        st_nxt.resValid = 1'b0;
        if (reqValid && st_r.rstSync[1] &&
            dac_op_type'(reqOp) != DAC_OP_NOP) begin
            st_nxt.resValid = !isCmp;
            st_nxt.comp = compSel;
            if (!isCmp) begin
                st_nxt.resDigit = (total > 5'h9) ? 4'h0 : total[3:0];
                st_nxt.carry = quiCarry;
            end else begin
                st_nxt.carry = quiCarry;
                st_nxt.high = (rel == DAC_REL_HI);
                st_nxt.low = (rel == DAC_REL_LO);
                st_nxt.equal = (rel == DAC_REL_EQ);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign resValid = st_r.resValid;
    assign resDigit = st_r.resDigit;
    assign carryLatch = st_r.carry;
    assign complementAdd = st_r.comp;
    assign cmpHigh = st_r.high;
    assign cmpLow = st_r.low;
    assign cmpEqual = st_r.equal;

endmodule : dac_unit

`default_nettype wire

/* dv/dac_unit_asserts.sv */
// Purpose: concurrent checks on the decimal adder and compare ports
// Assumes: arithmetic checks use plain digit characters 0-9
// Notes: bound to every dac_unit instance
`timescale 1ns/10ps
`default_nettype none
module dac_unit_asserts
    import dac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // channel request
    input wire logic reqValid,
    input wire logic [1:0] reqOp,
    input wire logic reqUnitsPos,
    input wire logic [CHAR_W-1:0] aChar,
    input wire logic [CHAR_W-1:0] bChar,
    input wire logic [CHAR_W-1:0] aUnitsChar,
    input wire logic [CHAR_W-1:0] bUnitsChar,
    // results
    input wire logic resValid,
    input wire logic [3:0] resDigit,
    input wire logic carryLatch,
    input wire logic complementAdd,
    input wire logic cmpHigh,
    input wire logic cmpLow,
    input wire logic cmpEqual
);
    logic [2:0] age_r;
    logic arith, cmpReq, plain, diff, tAdd;
    logic [4:0] tRaw, cRaw, tExp, cExp;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            age_r <= 3'h0;
        end else if (age_r != 3'h4) begin
            age_r <= age_r + 3'h1;
        end
    end
    // requests count only once the reset window has passed
    assign arith = reqValid && (age_r == 3'h4) && !reqOp[1];
    assign cmpReq = reqValid && (age_r == 3'h4) && (reqOp == 2'h2);
    assign plain = (aChar <= 6'h09) && (bChar <= 6'h09);
    assign diff = (aUnitsChar[5:4] == 2'h2) != (bUnitsChar[5:4] == 2'h2);
    assign tAdd = arith && plain && reqUnitsPos && (reqOp[0] == diff);
    always_comb begin
        tRaw = {1'b0, aChar[3:0]} + {1'b0, bChar[3:0]};
        cRaw = 5'h9 - {1'b0, aChar[3:0]} + {1'b0, bChar[3:0]} + 5'h1;
        tExp = (tRaw > 5'h9) ? tRaw + 5'h6 : tRaw;
        cExp = (cRaw > 5'h9) ? cRaw + 5'h6 : cRaw;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_res_pulse: assert property (arith |=> resValid)
        else $error("no result after add or subtract");
    a_res_quiet: assert property (
        (age_r == 3'h4) && !arith |=> !resValid)
        else $error("result without add or subtract");
    a_compl_select: assert property (
        arith |=> complementAdd == ($past(reqOp[0]) ^ $past(diff)))
        else $error("wrong true or complement choice");
    a_true_units: assert property (
        tAdd |=> {carryLatch, resDigit} == $past(tExp))
        else $error("true units sum wrong");
    a_comp_units: assert property (
        arith && plain && reqUnitsPos && !tAdd
        |=> {carryLatch, resDigit} == $past(cExp))
        else $error("complement units sum wrong");
    a_idle_hold: assert property (
        (age_r == 3'h4) && !arith && !cmpReq
        |=> $stable({resDigit, carryLatch, complementAdd}))
        else $error("result changed without request");
    a_cmp_onehot: assert property (
        cmpReq |=> $onehot({cmpHigh, cmpLow, cmpEqual}))
        else $error("compare latches not one-hot");
    a_cmp_hold: assert property (
        (age_r == 3'h4) && !cmpReq |=> $stable({cmpHigh, cmpLow, cmpEqual}))
        else $error("compare latches changed without compare");
    a_cmp_digit: assert property (
        cmpReq && plain && (aChar != 6'h0) && (bChar != 6'h0)
        |=> {cmpHigh, cmpEqual} == {$past(bChar) > $past(aChar),
                                    $past(bChar) == $past(aChar)})
        else $error("digit compare wrong");
    a_alpha_wins: assert property (
        cmpReq && (aChar > 6'h0a) && (aChar <= 6'h0f) && (bChar != 6'h0)
        && (bChar <= 6'h09) |=> cmpHigh)
        else $error("alphameric did not win over special");
    c_true: cover property (tAdd);
    c_comp: cover property (arith && !reqOp[0] && diff);
    c_equal: cover property (cmpReq ##1 cmpEqual);
endmodule : dac_unit_asserts
bind dac_unit dac_unit_asserts dac_unit_asserts_i (.ref_clk, .arst_n,
    .reqValid, .reqOp, .reqUnitsPos, .aChar, .bChar, .aUnitsChar,
    .bUnitsChar, .resValid, .resDigit, .carryLatch, .complementAdd,
    .cmpHigh, .cmpLow, .cmpEqual);
`default_nettype wire

/* dv/dac_channel_model.sv */
// Purpose: channel registers presenting character pairs to the unit
// Assumes: one pair per cycle, units position first
// Notes: on idle reqValid drops and the A and B character lines are inverted, the other lines keep their last value
`timescale 1ns/10ps
`default_nettype none
module dac_channel_model
    import dac_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // request to the unit
    output logic reqValid,
    output logic [1:0] reqOp,
    output logic reqUnitsPos,
    output logic [CHAR_W-1:0] aChar,
    output logic [CHAR_W-1:0] bChar,
    output logic [CHAR_W-1:0] aUnitsChar,
    output logic [CHAR_W-1:0] bUnitsChar
);
    initial begin
        reqValid = 1'b0;
        reqOp = 2'h3;
        reqUnitsPos = 1'b0;
        aChar = 6'h00;
        bChar = 6'h3f;
        aUnitsChar = 6'h00;
        bUnitsChar = 6'h00;
    end
    // drive after a falling edge, hold through the taking edge
    task automatic put(input logic [1:0] op, input logic u,
        input logic [5:0] a, b, au, bu);
        @(negedge ref_clk);
        reqValid = 1'b1;
        reqOp = op;
        reqUnitsPos = u;
        aChar = a;
        bChar = b;
        aUnitsChar = au;
        bUnitsChar = bu;
        @(posedge ref_clk);
        #1;
    endtask : put
    task automatic idle();
        @(negedge ref_clk);
        reqValid = 1'b0;
        aChar = ~aChar;
        bChar = ~bChar;
    endtask : idle
endmodule : dac_channel_model
`default_nettype wire

/* dv/dac_unit_tb.sv */
// Purpose: self-checking bench for the decimal adder and compare unit
// Assumes: expectations from decimal digit sums; carry into non-units steps read from carryLatch
// Notes: stimulus goes through the channel model tasks
`timescale 1ns/10ps
`default_nettype none
module dac_unit_tb
    import dac_pkg::*;
();
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reqValid, reqUnitsPos, resValid, carryLatch, complementAdd;
    logic cmpHigh, cmpLow, cmpEqual;
    logic [1:0] reqOp;
    logic [3:0] resDigit;
    logic [CHAR_W-1:0] aChar, bChar, aUnitsChar, bUnitsChar;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 ref_clk = ~ref_clk;
    dac_unit dac_unit_i (.ref_clk, .arst_n, .reqValid, .reqOp, .reqUnitsPos,
        .aChar, .bChar, .aUnitsChar, .bUnitsChar, .resValid, .resDigit,
        .carryLatch, .complementAdd, .cmpHigh, .cmpLow, .cmpEqual);
    dac_channel_model dac_channel_model_i (.ref_clk, .reqValid, .reqOp,
        .reqUnitsPos, .aChar, .bChar, .aUnitsChar, .bUnitsChar);
    // eight with three to seven acts as the low digit
    function automatic logic [3:0] tdig(input logic [5:0] c);
        return (c[3:0] > 4'h9) ? c[3:0] - 4'h8 : c[3:0];
    endfunction : tdig
    task automatic chk(input string nm, input logic [4:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic addStep(input logic [1:0] op, input logic u,
        input logic [5:0] a, b, au, bu);
        logic comp;
        logic [4:0] s;
        comp = op[0] ^ ((au[5:4] == 2'h2) != (bu[5:4] == 2'h2));
        s = (comp ? 5'h9 - {1'b0, tdig(a)} : {1'b0, tdig(a)})
            + {1'b0, tdig(b)} + {4'h0, (u ? comp : carryLatch)};
        dac_channel_model_i.put(op, u, a, b, au, bu);
        chk("complementAdd", {4'h0, comp}, {4'h0, complementAdd});
        chk("resValid", 5'h1, {4'h0, resValid});
        chk("sum", (s > 5'h9) ? s + 5'h6 : s, {carryLatch, resDigit});
    endtask : addStep
    task automatic cmpStep(input logic [5:0] a, b, input logic [2:0] exp);
        dac_channel_model_i.put(2'h2, 1'b1, a, b, a, b);
        chk("hle", {2'h0, exp}, {2'h0, cmpHigh, cmpLow, cmpEqual});
    endtask : cmpStep
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (5) @(posedge ref_clk);
        addStep(2'h0, 1'b1, 6'h07, 6'h08, 6'h00, 6'h00);
        addStep(2'h0, 1'b0, 6'h05, 6'h06, 6'h00, 6'h00);
        addStep(2'h0, 1'b0, 6'h00, 6'h00, 6'h00, 6'h00);
        for (int d = 0; d < 10; d++) begin
            addStep(2'h0, 1'b1, 6'(d), 6'(9 - d), 6'h00, 6'h00);
        end
        addStep(2'h0, 1'b1, 6'h0c, 6'h03, 6'h00, 6'h00);
        addStep(2'h0, 1'b0, 6'h33, 6'h21, 6'h00, 6'h00);
        addStep(2'h0, 1'b0, 6'h0f, 6'h0b, 6'h00, 6'h00);
        $display("add tests done");
        for (int z = 0; z < 4; z++) begin
            addStep(2'h0, 1'b1, 6'h04, 6'h02, {z[1:0], 4'h0}, 6'h00);
        end
        addStep(2'h1, 1'b1, 6'h03, 6'h05, 6'h00, 6'h00);
        addStep(2'h1, 1'b0, 6'h02, 6'h02, 6'h00, 6'h00);
        addStep(2'h1, 1'b1, 6'h03, 6'h05, 6'h00, 6'h20);
        dac_channel_model_i.idle();
        $display("sign tests done");
        cmpStep(6'h03, 6'h05, 3'h4);
        cmpStep(6'h07, 6'h03, 3'h2);
        cmpStep(6'h06, 6'h06, 3'h1);
        cmpStep(6'h09, 6'h08, 3'h2);
        cmpStep(6'h04, 6'h05, 3'h4);
        cmpStep(6'h0c, 6'h01, 3'h4);
        cmpStep(6'h01, 6'h0c, 3'h2);
        cmpStep(6'h01, 6'h31, 3'h2);
        $display("compare tests done");
        dac_channel_model_i.put(2'h3, 1'b1, 6'h05, 6'h05, 6'h00, 6'h00);
        chk("nopHle", 5'h2, {2'h0, cmpHigh, cmpLow, cmpEqual});
        chk("nopValid", 5'h0, {4'h0, resValid});
        dac_channel_model_i.idle();
        @(posedge ref_clk);
        #1;
        chk("idleValid", 5'h0, {4'h0, resValid});
        $display("refusal tests done");
        give_verdict();
    end
endmodule : dac_unit_tb
`default_nettype wire
